/* src/gate_diag_pkg.sv */
package gate_diag_pkg;

   // ------------------------------------------------------------
   // sizes and bus
   // ------------------------------------------------------------
   localparam int CH_N = 6;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int STAT_PER_WORD = 3;
   localparam int CODE_W = 3;

   // ------------------------------------------------------------
   // register map (word indices)
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_FAULT_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_GATE_CMD = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PULSE_REQ = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_OPEN_DIAG = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS_LO = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATUS_HI = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 4'h8;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int PULSE_ON_LSB = 8;
   localparam int CFG_BLANK_LSB = 5;
   localparam int CFG_BLANK_W = 4;
   localparam int CFG_THR_LSB = 9;
   localparam int CFG_THR_W = 3;
   localparam int BSEL_ON_LSB = 0;
   localparam int BSEL_OFF_LSB = 2;
   localparam int BSEL_W = 2;
   localparam int STAT_DIS_BIT = 9;
   localparam logic [CH_N-1:0] MODE_RST = 6'h00;
   localparam logic [CH_N-1:0] OPEN_DIAG_RST = 6'h3f;

   // ------------------------------------------------------------
   // status codes, smaller value wins
   // ------------------------------------------------------------
   localparam logic [CODE_W-1:0] ST_INVALID = 3'h0;
   localparam logic [CODE_W-1:0] ST_SCB = 3'h1;
   localparam logic [CODE_W-1:0] ST_SCG = 3'h2;
   localparam logic [CODE_W-1:0] ST_OLF = 3'h3;
   localparam logic [CODE_W-1:0] ST_DONE = 3'h4;
   localparam logic [CODE_W-1:0] ST_ON_OK = 3'h5;
   localparam logic [CODE_W-1:0] ST_OFF_OK = 3'h6;
   localparam logic [CODE_W-1:0] ST_NOT_DONE = 3'h7;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int BLANK_UNIT_NS = 10000;
   localparam int FILTER_NS = 5000;
   localparam int RETRY_US = 10000;
   localparam int BLANK_UNIT_CYC_DEF = (BLANK_UNIT_NS * CLK_MHZ + 999) / 1000;
   localparam int FILTER_CYC_DEF = (FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int RETRY_CYC_DEF = RETRY_US * CLK_MHZ;
   localparam int RETRY_W = 24;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic short_hi;
      logic below_gnd;
      logic below_open;
   } drain_fb_t;

   typedef struct packed {
      logic master_reset_low;
      logic master_disable;
      logic chip_select_low;
      logic [CH_N-1:0] cmd;
      drain_fb_t [CH_N-1:0] fb;
   } pins_t;

   typedef enum logic [1:0] {
      PULSE_NONE,
      PULSE_ON,
      PULSE_OFF
   } pulse_t;

endpackage : gate_diag_pkg

/* src/gate_fault_diag_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01: output turning on starts on-blanking; feedback sampled when it expires
// R02: output turning off starts off-blanking; feedback sampled when it expires
// R03: comparator change in stable state starts filter; sample at its end
// R04: filter may start while blanking runs, extending the window
// R05: per-channel timers; common filter time; blank select per channel
// R06: new blank select only used at next timer start
// R07: all blanking timers start when the device becomes enabled
// R08: on-state fault protects the FET; all faults set flag and code
// R09: status code priority: shorted load, then short to ground, then open
// R10: code only promoted; read or master reset restores not-complete
// R11: no diagnostics while reset or disabled; open-load per enable bit
// R12: host writes pulse requests; pulse fires at chip select rising edge
// R13: pulse skipped if disabled, both types, short latched, busy, retrying
// R14: off pulse forces open-load check, drives off for off-blank time
// R15: on pulse drives on for on-blank time then restores command
// R16: eight short threshold ratios selectable per channel
// R17: shorted load when comparator high at on-blank or filter end
// R18: per-channel recovery mode bit, latch-off by default
// R19: latch-off holds output off until disable toggle or pulse recovery
// R20: auto-retry holds output off for retry time, ignoring inputs
// R21: after retry output returns if commanded, resampled after blanking
// R22: one global retry timer started by the first faulted channel
// R23: status resets to all-ones not-complete code
// R24: status encoding 1..7 as defined, zero never produced
// R25: blank, filter and retry durations are clock-cycle parameters
module gate_fault_diag_control #(
   parameter int BLANK_UNIT_CYC = gate_diag_pkg::BLANK_UNIT_CYC_DEF,
   parameter int FILTER_CYC = gate_diag_pkg::FILTER_CYC_DEF,
   parameter int RETRY_CYC = gate_diag_pkg::RETRY_CYC_DEF
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [gate_diag_pkg::ADDR_W-1:0] addr_in,
   input wire logic [gate_diag_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [gate_diag_pkg::DATA_W-1:0] rd_data_out,
   input wire logic master_reset_low_in,
   input wire logic master_disable_in,
   input wire logic chip_select_low_in,
   input wire logic [gate_diag_pkg::CH_N-1:0] cmd_in,
   input wire gate_diag_pkg::drain_fb_t [gate_diag_pkg::CH_N-1:0] drain_feedback_in,
   output logic [gate_diag_pkg::CH_N-1:0] fet_drive_out,
   output logic [gate_diag_pkg::CH_N*gate_diag_pkg::CFG_THR_W-1:0] short_threshold_select_out,
   output logic fault_flag_low_out,
   output logic fault_flag_oe_low_out
);
   import gate_diag_pkg::*;

   localparam int BL_MAX = (1 << BSEL_W) * BLANK_UNIT_CYC;
   localparam int BL_W = $clog2(BL_MAX + 1);
   localparam int FL_W = $clog2(FILTER_CYC + 1);

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   if (BLANK_UNIT_CYC < 1 || FILTER_CYC < 1) begin : g_bad_time
      $error("blank unit and filter counts must be at least one cycle");
   end
   if (RETRY_CYC < 2 || RETRY_CYC >= (1 << RETRY_W)) begin : g_bad_retry
      $error("retry count out of counter range");
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   pins_t pin_s1_r;
   pins_t pin_s;
   logic cs_prev_r;
   logic act_r;
   logic act;
   logic act_rise;
   logic cs_rise;

   always_ff @(posedge clk_in) begin
      pin_s1_r <= {master_reset_low_in, master_disable_in, chip_select_low_in,
                   cmd_in, drain_feedback_in};
      pin_s <= pin_s1_r;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cs_prev_r <= 1'b1; // idle level: no false edge after reset
         act_r <= 1'b0;
      end else begin
         cs_prev_r <= pin_s.chip_select_low;
         act_r <= act;
      end
   end

   // enabled only with master reset released and master disable low
   assign act = !rst_in && pin_s.master_reset_low && !pin_s.master_disable; // R11
   assign act_rise = act && !act_r; // R07
   assign cs_rise = pin_s.chip_select_low && !cs_prev_r; // R12

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic regs_clr;
   logic [CH_N-1:0] mode_r;
   logic [CH_N-1:0] gate_r;
   logic [CH_N-1:0] ol_en_r;
   logic [CH_N-1:0] poff_r;
   logic [CH_N-1:0] pon_r;
   logic [CFG_BLANK_W-1:0] cfg_blank_r [CH_N];
   logic [CFG_THR_W-1:0] cfg_thr_r [CH_N];
   logic [DATA_W-1:0] rd_val;
   logic [CODE_W-1:0] code_v [CH_N];
   logic [CH_N-1:0] clr_v;
   logic [CH_N-1:0] rty_v;
   logic [CH_N-1:0] trig_v;
   logic [CH_N-1:0] fault_v;

   // master reset re-initialises every programmed field
   assign regs_clr = rst_in || !pin_s.master_reset_low;

   always_ff @(posedge clk_in) begin
      if (regs_clr) begin
         mode_r <= MODE_RST; // R18
         gate_r <= '0;
         ol_en_r <= OPEN_DIAG_RST;
      end else if (wr_in) begin
         case (addr_in)
            ADDR_FAULT_MODE: mode_r <= wr_data_in[CH_N-1:0]; // R18
            ADDR_GATE_CMD: gate_r <= wr_data_in[CH_N-1:0];
            ADDR_OPEN_DIAG: ol_en_r <= wr_data_in[CH_N-1:0]; // R11
            default: mode_r <= mode_r;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      for (int c = 0; c < CH_N; c++) begin
         if (regs_clr) begin
            cfg_blank_r[c] <= '0;
            cfg_thr_r[c] <= '0;
         end else if (wr_in && addr_in == ADDR_W'(int'(ADDR_CFG_BASE) + c)) begin
            // a running timer keeps its loaded length
            cfg_blank_r[c] <= wr_data_in[CFG_BLANK_LSB +: CFG_BLANK_W]; // R05 R06
            cfg_thr_r[c] <= wr_data_in[CFG_THR_LSB +: CFG_THR_W]; // R16
         end
      end
   end

   // requests are one-shot: consumed by the chip select rising edge
   always_ff @(posedge clk_in) begin
      if (regs_clr) begin
         poff_r <= '0;
         pon_r <= '0;
      end else if (wr_in && addr_in == ADDR_PULSE_REQ) begin
         poff_r <= wr_data_in[CH_N-1:0]; // R12
         pon_r <= wr_data_in[PULSE_ON_LSB +: CH_N]; // R12
      end else if (cs_rise) begin
         poff_r <= '0;
         pon_r <= '0;
      end
   end

   always_comb begin
      rd_val = '0;
      case (addr_in)
         ADDR_FAULT_MODE: rd_val[CH_N-1:0] = mode_r;
         ADDR_GATE_CMD: rd_val[CH_N-1:0] = gate_r;
         ADDR_PULSE_REQ: rd_val = {{(DATA_W - PULSE_ON_LSB - CH_N){1'b0}}, pon_r,
                                   {(PULSE_ON_LSB - CH_N){1'b0}}, poff_r};
         ADDR_OPEN_DIAG: rd_val[CH_N-1:0] = ol_en_r;
         ADDR_STATUS_LO, ADDR_STATUS_HI: begin
            // bit-sliced: low bits of the word's three channels first, then middle, then high
            for (int b = 0; b < CODE_W; b++) begin
               for (int j = 0; j < STAT_PER_WORD; j++) begin
                  rd_val[b * STAT_PER_WORD + j] =
                     code_v[(addr_in == ADDR_STATUS_HI ? STAT_PER_WORD : 0) + j][b];
               end
            end
            rd_val[STAT_DIS_BIT] = pin_s.master_disable;
         end
         default: begin
            for (int c = 0; c < CH_N; c++) begin
               if (addr_in == ADDR_W'(int'(ADDR_CFG_BASE) + c)) begin
                  rd_val[CFG_BLANK_LSB +: CFG_BLANK_W] = cfg_blank_r[c];
                  rd_val[CFG_THR_LSB +: CFG_THR_W] = cfg_thr_r[c];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out <= '0;
      end else if (rd_in) begin
         rd_data_out <= rd_val;
      end else begin
         rd_data_out <= '0;
      end
   end

   // ------------------------------------------------------------
   // global retry timer
   // ------------------------------------------------------------
   logic [RETRY_W-1:0] retry_cnt_r;
   logic retry_exp;

   assign retry_exp = (retry_cnt_r == RETRY_W'(1));

   // later channels join the running period and so may retry early
   always_ff @(posedge clk_in) begin
      if (!act) begin
         retry_cnt_r <= '0; // R20
      end else if (retry_cnt_r == '0) begin
         if (|trig_v) begin
            retry_cnt_r <= RETRY_W'(RETRY_CYC); // R22
         end
      end else if (!(|rty_v) && !(|trig_v)) begin
         retry_cnt_r <= '0; // R20
      end else begin
         retry_cnt_r <= retry_cnt_r - RETRY_W'(1); // R20
      end
   end

   // ------------------------------------------------------------
   // fault flag
   // ------------------------------------------------------------
   logic flag_low_r;

   // a new fault wins over the chip-select clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_low_r <= 1'b1;
      end else if (|fault_v) begin
         flag_low_r <= 1'b0; // R08
      end else if (!pin_s.chip_select_low || !act) begin
         flag_low_r <= 1'b1;
      end
   end

   assign fault_flag_low_out = 1'b0;
   assign fault_flag_oe_low_out = flag_low_r;

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < CH_N; i++) begin : g_ch
      drain_fb_t fb;
      pulse_t pulse_r;
      logic out_r;
      logic arm_r;
      logic latched_r;
      logic retry_r;
      logic cmp_prev_r;
      logic [BL_W-1:0] bl_cnt_r;
      logic [FL_W-1:0] flt_cnt_r;
      logic [CODE_W-1:0] code_r;
      logic nom;
      logic out_nxt;
      logic ol_eff;
      logic cmp_now;
      logic bl_start;
      logic bl_end;
      logic flt_end;
      logic smp;
      logic go;
      logic scb_evt;
      logic [BSEL_W-1:0] bsel;
      logic [BL_W-1:0] bl_len;
      logic [CODE_W-1:0] smp_code;
      logic [CODE_W-1:0] cur_code;

      always_comb begin
         fb = pin_s.fb[i];
         // faulted outputs ignore the command until recovered
         nom = act && (pin_s.cmd[i] || gate_r[i]) && !latched_r && !retry_r; // R19 R20
         out_nxt = act && ((pulse_r == PULSE_NONE) ? nom : (pulse_r == PULSE_ON)); // R13
         ol_eff = ol_en_r[i] || (pulse_r == PULSE_OFF); // R14
         cmp_now = out_r ? fb.short_hi : (fb.below_gnd || (fb.below_open && ol_eff));
         bl_start = act && ((out_nxt != out_r) || act_rise || arm_r); // R01 R02 R07
         bsel = out_nxt ? cfg_blank_r[i][BSEL_ON_LSB +: BSEL_W]
                        : cfg_blank_r[i][BSEL_OFF_LSB +: BSEL_W];
         bl_len = BL_W'((int'(bsel) + 1) * BLANK_UNIT_CYC); // R05 R25
         bl_end = (bl_cnt_r == BL_W'(1));
         flt_end = (flt_cnt_r == FL_W'(1));
         smp = act && (bl_end || (flt_end && bl_cnt_r == '0)); // R01 R02 R03 R04 R11
         if (out_r) begin
            smp_code = fb.short_hi ? ST_SCB : ST_ON_OK; // R17
         end else if (fb.below_gnd) begin
            smp_code = ST_SCG;
         end else if (fb.below_open && ol_eff) begin
            smp_code = ST_OLF; // R11
         end else begin
            smp_code = ST_OFF_OK;
         end
         scb_evt = smp && out_r && fb.short_hi; // R08 R17
         go = act && (pon_r[i] ^ poff_r[i]) && cs_rise && (code_r != ST_SCB)
              && (pulse_r == PULSE_NONE) && (bl_cnt_r == '0) && !retry_r; // R12 R13
         cur_code = clr_v[i] ? ST_NOT_DONE : code_r; // R10
      end

      // output and blanking timer
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            out_r <= 1'b0;
            bl_cnt_r <= '0;
         end else begin
            out_r <= out_nxt;
            if (!act) begin
               bl_cnt_r <= '0;
            end else if (bl_start) begin
               bl_cnt_r <= bl_len; // R01 R02 R06
            end else if (bl_cnt_r != '0) begin
               bl_cnt_r <= bl_cnt_r - BL_W'(1);
            end
         end
      end

      // filter timer, independent of blanking
      always_ff @(posedge clk_in) begin
         if (rst_in || !act) begin
            cmp_prev_r <= 1'b0;
            flt_cnt_r <= '0;
         end else begin
            cmp_prev_r <= cmp_now;
            if (cmp_now != cmp_prev_r) begin
               flt_cnt_r <= FL_W'(FILTER_CYC); // R03 R04 R05
            end else if (flt_cnt_r != '0) begin
               flt_cnt_r <= flt_cnt_r - FL_W'(1);
            end
         end
      end

      // diagnostic pulse
      always_ff @(posedge clk_in) begin
         if (rst_in || !act) begin
            pulse_r <= PULSE_NONE;
            arm_r <= 1'b0;
         end else if (go) begin
            pulse_r <= pon_r[i] ? PULSE_ON : PULSE_OFF; // R14 R15
            arm_r <= 1'b1;
         end else begin
            arm_r <= 1'b0;
            if (pulse_r != PULSE_NONE && !arm_r && (bl_end || scb_evt)) begin
               pulse_r <= PULSE_NONE; // R14 R15
            end
         end
      end

      // protection
      always_ff @(posedge clk_in) begin
         if (rst_in || !act) begin
            latched_r <= 1'b0; // R19
            retry_r <= 1'b0;
         end else begin
            if (go) begin
               latched_r <= 1'b0; // R19
            end else if (scb_evt && !mode_r[i]) begin
               latched_r <= 1'b1; // R08 R19
            end
            if (!mode_r[i]) begin
               retry_r <= 1'b0; // R20
            end else if (scb_evt) begin
               retry_r <= 1'b1; // R08 R20
            end else if (retry_exp) begin
               retry_r <= 1'b0; // R21
            end
         end
      end

      // status code, promoted only; a sample beats a read clear
      always_ff @(posedge clk_in) begin
         if (regs_clr) begin
            code_r <= ST_NOT_DONE; // R10 R23
         end else if (smp) begin
            if ((cur_code == ST_ON_OK && smp_code == ST_OFF_OK)
                || (cur_code == ST_OFF_OK && smp_code == ST_ON_OK)) begin
               code_r <= ST_DONE; // R24
            end else if (smp_code < cur_code) begin
               code_r <= smp_code; // R09 R10
            end else begin
               code_r <= cur_code;
            end
         end else begin
            code_r <= cur_code; // R10
         end
      end

      assign code_v[i] = code_r;
      assign clr_v[i] = rd_in
         && (addr_in == ADDR_W'(int'(ADDR_STATUS_LO) + i / STAT_PER_WORD));
      assign rty_v[i] = retry_r;
      assign trig_v[i] = scb_evt && mode_r[i]; // R22
      assign fault_v[i] = smp && (smp_code <= ST_OLF) && (smp_code != ST_INVALID);
      assign fet_drive_out[i] = out_r;
      assign short_threshold_select_out[i * CFG_THR_W +: CFG_THR_W] = cfg_thr_r[i]; // R16
   end

endmodule : gate_fault_diag_control
`default_nettype wire

/* bench/fet_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fet_load_model (
   input wire logic [gate_diag_pkg::CH_N-1:0] drive_in,
   input wire logic [gate_diag_pkg::CH_N-1:0] short_in,
   input wire logic [gate_diag_pkg::CH_N-1:0] open_in,
   input wire logic [gate_diag_pkg::CH_N-1:0] gnd_in,
   output var gate_diag_pkg::drain_fb_t [gate_diag_pkg::CH_N-1:0] fb_out
);
   import gate_diag_pkg::*;
   // ----------------------------------------
   // drain levels
   // ----------------------------------------
   // a healthy off drain sits at load supply, so it is above the short reference
   always_comb begin
      for (int i = 0; i < CH_N; i++) begin
         if (drive_in[i])
            fb_out[i] = '{short_in[i], 1'b0, 1'b0};
         else
            fb_out[i] = '{!(open_in[i] | gnd_in[i]), gnd_in[i], open_in[i] | gnd_in[i]};
      end
   end
endmodule : fet_load_model
`default_nettype wire

/* bench/gate_fault_diag_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module gate_fault_diag_control_chk (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [gate_diag_pkg::ADDR_W-1:0] addr_in,
   input wire logic [gate_diag_pkg::DATA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [gate_diag_pkg::DATA_W-1:0] rd_data_out,
   input wire logic master_reset_low_in,
   input wire logic master_disable_in,
   input wire logic [gate_diag_pkg::CH_N-1:0] fet_drive_out,
   input wire logic [gate_diag_pkg::CH_N*gate_diag_pkg::CFG_THR_W-1:0] short_threshold_select_out,
   input wire logic fault_flag_low_out,
   input wire logic fault_flag_oe_low_out
);
   import gate_diag_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   sequence s_stat_rd;
      rd_in && (addr_in == ADDR_STATUS_LO || addr_in == ADDR_STATUS_HI);
   endsequence
   // four samples cover the two sync stages plus the output register
   sequence s_dis_held;
      master_disable_in [*4];
   endsequence
   sequence s_mrst_held;
      !master_reset_low_in [*4];
   endsequence
   property p_thr_wr;
      (wr_in && addr_in == ADDR_CFG_BASE && master_reset_low_in)
         |=> short_threshold_select_out[2:0] == $past(wr_data_in[11:9]);
   endproperty
   chk_rd_idle_zero: assert property (!rd_in |=> rd_data_out == '0)
      else $error("read data not zero outside read slot");
   chk_stat_code_valid: assert property (
      s_stat_rd |=> (rd_data_out[2:0] | rd_data_out[5:3] | rd_data_out[8:6]) == 3'h7)
      else $error("status code zero returned");
   chk_dis_drive_off: assert property (s_dis_held |=> fet_drive_out == '0)
      else $error("drive on while disabled");
   chk_dis_flag_off: assert property (s_dis_held |=> fault_flag_oe_low_out)
      else $error("flag driven while disabled");
   chk_mrst_all_off: assert property (
      s_mrst_held |=> fet_drive_out == '0 && fault_flag_oe_low_out)
      else $error("outputs active in master reset");
   chk_flag_pin_low: assert property (fault_flag_low_out == 1'b0)
      else $error("flag pin value not low");
   chk_thr_hold: assert property (
      (!wr_in && master_reset_low_in) [*4] |=> $stable(short_threshold_select_out))
      else $error("threshold select changed without write");
   chk_thr_write: assert property (p_thr_wr)
      else $error("threshold select not updated by write");
endmodule : gate_fault_diag_control_chk
bind gate_fault_diag_control gate_fault_diag_control_chk u_chk (.clk_in, .rst_in, .addr_in,
   .wr_data_in, .wr_in, .rd_in, .rd_data_out, .master_reset_low_in, .master_disable_in,
   .fet_drive_out, .short_threshold_select_out, .fault_flag_low_out, .fault_flag_oe_low_out);
`default_nettype wire

/* bench/gate_fault_diag_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gate_fault_diag_control_tb;
   import gate_diag_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [DATA_W-1:0] wr_data_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic master_reset_low_in = 1'b1;
   logic master_disable_in = 1'b0;
   logic chip_select_low_in = 1'b1;
   logic [CH_N-1:0] cmd_in = '0;
   logic [CH_N-1:0] short_m = '0, open_m = '0, gnd_m = '0;
   drain_fb_t [CH_N-1:0] drain_feedback_in;
   logic [DATA_W-1:0] rd_data_out;
   logic [DATA_W-1:0] v;
   logic [CH_N-1:0] fet_drive_out;
   logic [CH_N*CFG_THR_W-1:0] short_threshold_select_out;
   logic fault_flag_low_out;
   logic fault_flag_oe_low_out;
   int err_count = 0;
   int num_checks = 0;
   always #4 clk_in = ~clk_in;
   // short counts keep each scenario to tens of cycles
   gate_fault_diag_control #(.BLANK_UNIT_CYC(8), .FILTER_CYC(4), .RETRY_CYC(40))
      u_gate_fault_diag_control (.clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
      .rd_data_out, .master_reset_low_in, .master_disable_in, .chip_select_low_in, .cmd_in,
      .drain_feedback_in, .fet_drive_out, .short_threshold_select_out, .fault_flag_low_out,
      .fault_flag_oe_low_out);
   fet_load_model u_fet_load_model (.drive_in(fet_drive_out), .short_in(short_m),
      .open_in(open_m), .gnd_in(gnd_m), .fb_out(drain_feedback_in));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      d = rd_data_out;
   endtask : rd
   task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string n);
      rd(a, v);
      chk(n, e, v);
   endtask : rdc
   task automatic wait_fet(input int ch, input logic b, input int n, input string s);
      for (int i = 0; i < n && fet_drive_out[ch] !== b; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk(s, {15'h0, b}, {15'h0, fet_drive_out[ch]});
   endtask : wait_fet
   task automatic hold_fet(input int ch, input logic b, input int n, input string s);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(posedge clk_in);
         #1;
         if (fet_drive_out[ch] !== b) ok = 1'b0;
      end
      chk(s, 16'h1, {15'h0, ok});
   endtask : hold_fet
   task automatic cs_pulse;
      chip_select_low_in <= 1'b0;
      cyc(3);
      chip_select_low_in <= 1'b1;
   endtask : cs_pulse
   function automatic logic [15:0] st(input logic [2:0] a, input logic [2:0] b,
      input logic [2:0] c, input logic d);
      return {6'h0, d, c[2], b[2], a[2], c[1], b[1], a[1], c[0], b[0], a[0]};
   endfunction : st
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      cyc(20);
      rst_in <= 1'b0;
      rdc(ADDR_STATUS_LO, st(3'h7, 3'h7, 3'h7, 1'b0), "stat_rst");
      rdc(ADDR_FAULT_MODE, 16'h0, "mode_rst");
      rdc(ADDR_OPEN_DIAG, 16'h3f, "olen_rst");
      rdc(4'hf, 16'h0, "unmapped");
      for (int i = 0; i < CH_N; i++)
         wr(ADDR_CFG_BASE + 4'(i), (16'(i + 2) << 9) | (i == 1 ? 16'h0040 : 16'h0));
      cyc(2);
      for (int i = 0; i < CH_N; i++)
         chk("thr", 16'(i + 2), 16'(short_threshold_select_out[3*i +: 3]));
      $display("test reset done");
      rd(ADDR_STATUS_LO, v);
      cmd_in[0] <= 1'b1;
      wait_fet(0, 1'b1, 6, "on0");
      cyc(15);
      rdc(ADDR_STATUS_LO, st(3'h5, 3'h7, 3'h7, 1'b0), "on_clean");
      short_m[1] <= 1'b1;
      cmd_in[1] <= 1'b1;
      wait_fet(1, 1'b1, 6, "on1");
      hold_fet(1, 1'b1, 20, "blank_len");
      wait_fet(1, 1'b0, 12, "latch_off");
      chk("flag", 16'h0, {15'h0, fault_flag_oe_low_out});
      rdc(ADDR_STATUS_LO, st(3'h7, 3'h1, 3'h7, 1'b0), "scb");
      short_m[1] <= 1'b0;
      master_disable_in <= 1'b1;
      cyc(6);
      rd(ADDR_STATUS_HI, v);
      chk("dis_bit", 16'h0200, v & 16'h0200);
      master_disable_in <= 1'b0;
      wait_fet(1, 1'b1, 30, "recover");
      $display("test short done");
      open_m[3] <= 1'b1;
      gnd_m[4] <= 1'b1;
      open_m[5] <= 1'b1;
      wr(ADDR_OPEN_DIAG, 16'h1f);
      master_disable_in <= 1'b1;
      cyc(6);
      rd(ADDR_STATUS_HI, v);
      master_disable_in <= 1'b0;
      cyc(25);
      rdc(ADDR_STATUS_HI, st(3'h3, 3'h2, 3'h6, 1'b0), "off_diag");
      rdc(ADDR_STATUS_HI, st(3'h7, 3'h7, 3'h7, 1'b0), "rd_clear");
      $display("test off done");
      wr(ADDR_FAULT_MODE, 16'h04);
      short_m[2] <= 1'b1;
      cmd_in[2] <= 1'b1;
      wait_fet(2, 1'b1, 6, "on2");
      wait_fet(2, 1'b0, 15, "retry_off");
      hold_fet(2, 1'b0, 30, "retry_hold");
      wait_fet(2, 1'b1, 20, "retry_on");
      wait_fet(2, 1'b0, 15, "retry_again");
      cmd_in[2] <= 1'b0;
      short_m[2] <= 1'b0;
      $display("test retry done");
      wr(ADDR_PULSE_REQ, 16'h0101);
      cs_pulse();
      hold_fet(0, 1'b1, 15, "both_skip");
      wr(ADDR_PULSE_REQ, 16'h0001);
      cs_pulse();
      wait_fet(0, 1'b0, 8, "off_pulse");
      wait_fet(0, 1'b1, 20, "off_end");
      wr(ADDR_PULSE_REQ, 16'h0800);
      cs_pulse();
      wait_fet(3, 1'b1, 8, "on_pulse");
      wait_fet(3, 1'b0, 20, "on_end");
      $display("test pulse done");
      master_reset_low_in <= 1'b0;
      cyc(6);
      master_reset_low_in <= 1'b1;
      cyc(3);
      rdc(ADDR_STATUS_LO, st(3'h7, 3'h7, 3'h7, 1'b0), "mrst_stat");
      rdc(ADDR_FAULT_MODE, 16'h0, "mrst_mode");
      $display("test master reset done");
      close_out();
   end
   // whole run is at most about 400 cycles; ten times that means a hang
   initial begin
      #(8 * 4000);
      err_count++;
      close_out();
   end
endmodule : gate_fault_diag_control_tb
`default_nettype wire
